// File: design/bne_page_ecc.v
// NAND page BCH redundancy and remainder engine with a plain register port.
`timescale 1ns/1ps
`include "bne_consts.vh"

// What this block does
// - Redundancy byte count follows capability, sector size.
// - Remainder word count follows capability code.
// - Protected spare continues last sector's stream.
// - Data start command runs page processing.
// - Protected read skips programmed ECC range.
// - Unprotected spare: redundancy taken straight, no skipping.
// - Automatic field fetches ECC when spare unprotected, else user mode.
// - Unprotected write excludes spare bytes.
// - Sector size selectable 512 or 1024 bytes.
// - All-zero remainder means sector error free.
// - Corrupted sector sets status bit, interrupt when its mask bit is set.
module bne_page_ecc (
    input  wire        clk,
    input  wire        reset,
    input  wire [9:0]  addr,
    input  wire [31:0] wdata,
    input  wire        wr,
    input  wire        rd,
    output wire [31:0] rdata,
    input  wire [7:0]  nand_data,
    input  wire        nand_valid,
    output wire        irq
);

    localparam [1:0] ST_IDLE  = 2'h0;
    localparam [1:0] ST_DATA  = 2'h1;
    localparam [1:0] ST_SPARE = 2'h2;
    localparam [1:0] ST_ECC   = 2'h3;

    reg [31:0]          cfg_r;
    reg [8:0]           sarea_r;
    reg [8:0]           saddr_r;
    reg [8:0]           eaddr_r;
    reg [7:0]           mask_r;
    reg [7:0]           isr_r;
    reg [31:0]          rdata_r;
    reg                 irq_r;
    reg [1:0]           st_r;
    reg [9:0]           cnt_r;
    reg [2:0]           sec_r;
    reg [5:0]           eb_r;
    reg [`BNE_RW-1:0]   lfsr_r;
    reg [`BNE_RW-1:0]   res_mem [0:7];

    // Redundancy bytes per sector for each capability code.
    function [5:0] ecc_bytes;
        input [2:0] cap;
        input       big;
        begin
            case (cap)
                3'h0:    ecc_bytes = 6'h04;
                3'h1:    ecc_bytes = 6'h07;
                3'h2:    ecc_bytes = big ? 6'h0E : 6'h0D;
                3'h3:    ecc_bytes = big ? 6'h15 : 6'h14;
                default: ecc_bytes = big ? 6'h2A : 6'h27;
            endcase
        end
    endfunction

    // Remainder words per sector, independent of sector size.
    function [3:0] rem_words;
        input [2:0] cap;
        begin
            case (cap)
                3'h0:    rem_words = 4'h1;
                3'h1:    rem_words = 4'h2;
                3'h2:    rem_words = 4'h4;
                3'h3:    rem_words = 4'h8;
                default: rem_words = 4'hC;
            endcase
        end
    endfunction

    // Divides one byte, MSB first, into the running remainder of len bits.
    function [`BNE_RW-1:0] lfsr_byte;
        input [`BNE_RW-1:0] s;
        input [7:0]         d;
        input [8:0]         len;
        integer             i;
        reg [`BNE_RW-1:0]   v;
        reg [`BNE_RW-1:0]   m;
        reg                 fb;
        begin
            v = s;
            m = {`BNE_RW{1'b1}} >> (`BNE_RW - len);
            for (i = 7; i >= 0; i = i - 1) begin
                fb = d[i] ^ v[len - 9'h001];
                v  = ((v << 1) ^ (fb ? `BNE_GEN_POLY : {`BNE_RW{1'b0}})) & m;
            end
            lfsr_byte = v;
        end
    endfunction

    wire [2:0] cap       = cfg_r[`BNE_CFG_CAP_LSB +: 3];
    wire       big_sec   = cfg_r[`BNE_CFG_SECT];
    wire [1:0] nsec_f    = cfg_r[`BNE_CFG_NSEC_LSB +: 2];
    wire       wr_dir    = cfg_r[`BNE_CFG_WRDIR];
    wire       spare_en  = cfg_r[`BNE_CFG_SPARE];
    wire       auto_en   = cfg_r[`BNE_CFG_AUTO];
    wire [5:0] nbytes    = ecc_bytes(cap, big_sec);
    wire [8:0] len_bits  = {nbytes, 3'b000};
    wire [2:0] last_sec  = (3'b001 << nsec_f) - 3'b001;
    wire [9:0] sec_end   = big_sec ? `BNE_SEC_END_1K : `BNE_SEC_END_512;
    wire       cap_ok    = cap <= `BNE_CAP_MAX;
    wire       wr_cmd    = wr && addr == `BNE_OFS_CTRL;
    wire       start     = wr_cmd && wdata[`BNE_CTRL_DATA] && cap_ok;
    wire       user      = wr_cmd && wdata[`BNE_CTRL_USER] && !wr_dir && !start;
    wire       byte_in   = nand_valid;
    wire [`BNE_RW-1:0] lfsr_step = lfsr_byte(lfsr_r, nand_data, len_bits);
    wire       in_skip   = !spare_en ? 1'b0 :
                           ({1'b0, saddr_r} <= cnt_r) && (cnt_r <= {1'b0, eaddr_r});
    wire       sec_done  = (st_r == ST_DATA) && byte_in && cnt_r == sec_end;
    wire       spare_done = (st_r == ST_SPARE) && byte_in && cnt_r == {1'b0, sarea_r} - 10'h001;
    wire       ecc_last  = (st_r == ST_ECC) && byte_in && eb_r == nbytes - 6'h01 && sec_r == last_sec;
    wire [`BNE_RW-1:0] ecc_byte_v = {{(`BNE_RW-8){1'b0}}, nand_data} << {eb_r, 3'b000};

    // Sector check: any nonzero remainder bit marks the sector corrupted.
    reg [7:0] bad_v;
    integer   k;
    always @* begin
        bad_v = 8'h00;
        for (k = 0; k < 8; k = k + 1) begin
            if (k[2:0] <= last_sec) begin
                if (k[2:0] == sec_r) begin
                    bad_v[k] = |(res_mem[k] ^ ecc_byte_v);
                end else begin
                    bad_v[k] = |res_mem[k];
                end
            end
        end
    end

    wire [7:0] err_set = ecc_last ? bad_v : 8'h00;

    // Data path state machine.
    always @(posedge clk) begin
        if (reset) begin
            st_r   <= ST_IDLE;
            cnt_r  <= 10'h000;
            sec_r  <= 3'h0;
            eb_r   <= 6'h00;
            lfsr_r <= {`BNE_RW{1'b0}};
        end else if (start) begin
            st_r   <= ST_DATA;
            cnt_r  <= 10'h000;
            sec_r  <= 3'h0;
            eb_r   <= 6'h00;
            lfsr_r <= {`BNE_RW{1'b0}};
        end else if (user) begin
            st_r  <= ST_ECC;
            sec_r <= 3'h0;
            eb_r  <= 6'h00;
        end else if (byte_in) begin
            case (st_r)
                ST_DATA: begin
                    lfsr_r <= lfsr_step;
                    cnt_r  <= cnt_r + 10'h001;
                    if (sec_done) begin
                        cnt_r <= 10'h000;
                        if (sec_r != last_sec) begin
                            lfsr_r <= {`BNE_RW{1'b0}};
                            sec_r  <= sec_r + 3'h1;
                        end else if (spare_en && sarea_r != 9'h000) begin
                            st_r <= ST_SPARE;
                        end else if (!wr_dir && auto_en) begin
                            st_r  <= ST_ECC;
                            sec_r <= 3'h0;
                        end else begin
                            st_r <= ST_IDLE;
                        end
                    end
                end
                ST_SPARE: begin
                    if (!in_skip) begin
                        lfsr_r <= lfsr_step;
                    end
                    cnt_r <= cnt_r + 10'h001;
                    if (spare_done) begin
                        st_r  <= ST_IDLE;
                        cnt_r <= 10'h000;
                    end
                end
                ST_ECC: begin
                    eb_r <= eb_r + 6'h01;
                    if (eb_r == nbytes - 6'h01) begin
                        eb_r <= 6'h00;
                        if (sec_r == last_sec) begin
                            st_r <= ST_IDLE;
                        end else begin
                            sec_r <= sec_r + 3'h1;
                        end
                    end
                end
                default: begin
                    st_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Per-sector results: stored remainder, then folded with received ECC bytes.
    always @(posedge clk) begin
        if (sec_done) begin
            res_mem[sec_r] <= lfsr_step;
        end else if (spare_done) begin
            res_mem[sec_r] <= in_skip ? lfsr_r : lfsr_step;
        end else if (st_r == ST_ECC && byte_in && !start && !user) begin
            res_mem[sec_r] <= res_mem[sec_r] ^ ecc_byte_v;
        end
    end

    // Register file, read data and interrupt.
    wire [9:0] res_off  = addr - `BNE_OFS_RES_BASE;
    wire [2:0] rsec     = res_off[8:6];
    wire [3:0] rword    = res_off[5:2];
    wire [3:0] nwords   = wr_dir ? ({nbytes[5:2]} + {3'h0, |nbytes[1:0]}) : rem_words(cap);
    wire       rd_isr   = rd && addr == `BNE_OFS_ISR;
    reg [31:0] rd_v;
    always @* begin
        rd_v = 32'h00000000;
        if (addr == `BNE_OFS_CFG) begin
            rd_v = cfg_r;
        end else if (addr == `BNE_OFS_SAREA) begin
            rd_v = {23'h000000, sarea_r};
        end else if (addr == `BNE_OFS_SADDR) begin
            rd_v = {23'h000000, saddr_r};
        end else if (addr == `BNE_OFS_EADDR) begin
            rd_v = {23'h000000, eaddr_r};
        end else if (addr == `BNE_OFS_SR) begin
            rd_v = {25'h0000000, sec_r, 2'b00, st_r != ST_ECC && st_r != ST_IDLE, st_r != ST_IDLE};
        end else if (addr == `BNE_OFS_MASK) begin
            rd_v = {24'h000000, mask_r};
        end else if (addr == `BNE_OFS_ISR) begin
            rd_v = {24'h000000, isr_r};
        end else if (addr >= `BNE_OFS_RES_BASE && addr < `BNE_OFS_RES_END && addr[1:0] == 2'b00) begin
            if (rword < nwords) begin
                rd_v = res_mem[rsec][{rword, 5'h00} +: 32];
            end
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            cfg_r   <= `BNE_CFG_RESET;
            sarea_r <= `BNE_SAREA_RESET;
            saddr_r <= `BNE_ADDR_RESET;
            eaddr_r <= `BNE_ADDR_RESET;
            mask_r  <= `BNE_MASK_RESET;
            rdata_r <= 32'h00000000;
        end else begin
            if (wr) begin
                if (addr == `BNE_OFS_CFG) begin
                    cfg_r <= wdata;
                end else if (addr == `BNE_OFS_SAREA) begin
                    sarea_r <= wdata[8:0];
                end else if (addr == `BNE_OFS_SADDR) begin
                    saddr_r <= wdata[8:0];
                end else if (addr == `BNE_OFS_EADDR) begin
                    eaddr_r <= wdata[8:0];
                end else if (addr == `BNE_OFS_MASK) begin
                    mask_r <= wdata[7:0];
                end
            end
            rdata_r <= rd ? rd_v : 32'h00000000;
        end
    end

    // Sector error status and the level interrupt.
    // The status records every corrupted sector whatever the mask holds.
    // The interrupt follows the status one cycle later, so it never glitches.
    always @(posedge clk) begin
        if (reset) begin
            isr_r <= 8'h00;
            irq_r <= 1'b0;
        end else begin
            // A sector error arriving with the clearing read stays set.
            isr_r <= (rd_isr ? 8'h00 : isr_r) | err_set;
            irq_r <= |(isr_r & mask_r);
        end
    end

    assign rdata = rdata_r;
    assign irq   = irq_r;

endmodule // bne_page_ecc

// File: design/bne_consts.vh
// Constants for the NAND page BCH flow block: offsets, fields, reset values, sizes.
`ifndef BNE_CONSTS_VH
`define BNE_CONSTS_VH

`define BNE_OFS_CFG      10'h000
`define BNE_OFS_SAREA    10'h004
`define BNE_OFS_SADDR    10'h008
`define BNE_OFS_EADDR    10'h00C
`define BNE_OFS_CTRL     10'h014
`define BNE_OFS_SR       10'h018
`define BNE_OFS_MASK     10'h024
`define BNE_OFS_ISR      10'h028
`define BNE_OFS_RES_BASE 10'h040
`define BNE_OFS_RES_END  10'h240

`define BNE_CFG_CAP_LSB  0
`define BNE_CFG_SECT     4
`define BNE_CFG_NSEC_LSB 8
`define BNE_CFG_WRDIR    12
`define BNE_CFG_SPARE    16
`define BNE_CFG_AUTO     20
`define BNE_CTRL_DATA    1
`define BNE_CTRL_USER    2

`define BNE_CFG_RESET    32'h00000000
`define BNE_SAREA_RESET  9'h000
`define BNE_ADDR_RESET   9'h000
`define BNE_MASK_RESET   8'h00

`define BNE_CAP_MAX      3'h4
`define BNE_SEC_END_512  10'h1FF
`define BNE_SEC_END_1K   10'h3FF
`define BNE_RW           384
`define BNE_GEN_POLY     {48{8'hA7}}

`endif

// File: test/bne_page_ecc_assertions.sv
// Port-level assertions for the NAND page BCH engine.
`timescale 1ns/1ps
`include "bne_consts.vh"
module bne_page_ecc_chk (
    input wire        clk,
    input wire        reset,
    input wire [9:0]  addr,
    input wire [31:0] wdata,
    input wire        wr,
    input wire        rd,
    input wire [31:0] rdata,
    input wire [7:0]  nand_data,
    input wire        nand_valid,
    input wire        irq
);
    a_rdata_idle_zero: assert property (@(posedge clk) disable iff (reset) !rd |=> rdata == 32'h0)
        else $error("read data not zero outside a read");
    a_reset_clears_out: assert property (@(posedge clk) reset |=> rdata == 32'h0 && !irq)
        else $error("outputs not cleared by reset");
    a_unmapped_reads_zero: assert property (@(posedge clk) disable iff (reset) rd && addr >= 10'h240 |=> rdata == 32'h0)
        else $error("unmapped read not zero");
    a_ctrl_reads_zero: assert property (@(posedge clk) disable iff (reset)
        rd && (addr == `BNE_OFS_CTRL || addr == 10'h010) |=> rdata == 32'h0) else $error("control read not zero");
    a_result_tail_zero: assert property (@(posedge clk) disable iff (reset)
        rd && addr >= 10'h040 && addr < 10'h240 && addr[5:0] >= 6'h30 |=> rdata == 32'h0) else $error("tail word set");
    a_irq_has_cause: assert property (@(posedge clk) disable iff (reset)
        !$stable(irq) |-> $past(nand_valid, 2) || $past(wr, 2) || $past(rd, 2)) else $error("irq moved alone");
    a_isr_read_clears: assert property (@(posedge clk) disable iff (reset)
        rd && addr == `BNE_OFS_ISR && !nand_valid ##1 !nand_valid |=> !irq) else $error("irq kept after read");
    a_mask_gates_irq: assert property (@(posedge clk) disable iff (reset)
        wr && addr == `BNE_OFS_MASK && wdata[7:0] == 8'h00 ##1 !(wr && addr == `BNE_OFS_MASK) |=> !irq)
        else $error("irq high with zero mask");
    a_mask_read_back: assert property (@(posedge clk) disable iff (reset)
        wr && addr == `BNE_OFS_MASK ##1 !wr ##1 rd && addr == `BNE_OFS_MASK |=> rdata[7:0] == $past(wdata[7:0], 3))
        else $error("mask read back wrong");
endmodule // bne_page_ecc_chk

bind bne_page_ecc bne_page_ecc_chk u_chk (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .nand_data(nand_data), .nand_valid(nand_valid), .irq(irq));

// File: test/bne_nand_src.sv
// NAND stream source that plays page data, spare bytes and stored ECC bytes.
`timescale 1ns/1ps
module bne_nand_src (
    input  wire        clk,
    input  wire        go,
    input  wire [10:0] n_bytes,
    input  wire [10:0] flip_at,
    input  wire [5:0]  ecc_n,
    output reg  [7:0]  nand_data,
    output reg         nand_valid,
    output reg         busy
);
    reg [7:0]  ecc_mem [0:63];
    reg [11:0] cnt = 12'h000;
    initial nand_data = 8'h00;
    initial nand_valid = 1'b0;
    initial busy = 1'b0;
    // While no byte is valid the data lines toggle so a stale byte is never seen as valid.
    always @(posedge clk) begin
        nand_valid <= 1'b0;
        nand_data  <= ~nand_data;
        if (go) begin
            cnt  <= 12'h000;
            busy <= 1'b1;
        end else if (busy) begin
            nand_valid <= 1'b1;
            if (cnt < n_bytes)
                nand_data <= cnt[7:0] ^ {cnt[10:8], 5'h0A} ^ ((cnt == flip_at) ? 8'h10 : 8'h00);
            else
                nand_data <= ecc_mem[cnt[5:0] - n_bytes[5:0]];
            cnt  <= cnt + 12'h001;
            busy <= (cnt + 12'h001) < (n_bytes + ecc_n);
        end
    end
endmodule // bne_nand_src

// File: test/testbench.sv
// Self-checking bench for the NAND page BCH engine.
`timescale 1ns/1ps
`include "bne_consts.vh"
module testbench;
    reg         clk = 1'b0;
    reg         reset = 1'b1;
    reg  [9:0]  addr = 10'h000;
    reg  [31:0] wdata = 32'h0;
    reg         wr = 1'b0;
    reg         rd = 1'b0;
    reg         go = 1'b0;
    reg  [10:0] n_bytes = 11'h200;
    reg  [10:0] flip_at = 11'h7FF;
    reg  [5:0]  ecc_n = 6'h00;
    wire [31:0] rdata;
    wire [7:0]  nand_data;
    wire        nand_valid;
    wire        irq;
    wire        busy;
    reg  [31:0] red [0:11];
    reg  [31:0] v;
    reg  [31:0] base;
    reg  [31:0] p;
    int         n_fail = 0;
    int         tests_run = 0;
    int         nbt [10] = '{4, 7, 13, 20, 39, 4, 7, 14, 21, 42};
    int         rwt [5] = '{1, 2, 4, 8, 12};
    int         c;
    int         w;
    int         nw;

    bne_page_ecc u_bne_page_ecc (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .nand_data(nand_data), .nand_valid(nand_valid), .irq(irq));
    bne_nand_src u_bne_nand_src (.clk(clk), .go(go), .n_bytes(n_bytes), .flip_at(flip_at), .ecc_n(ecc_n),
        .nand_data(nand_data), .nand_valid(nand_valid), .busy(busy));

    always #50 clk = ~clk;

    task finish_test;
        if (n_fail == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task chk(input string name, input [31:0] exp, input [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task wr_reg(input [9:0] a, input [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask
    task rd_reg(input [9:0] a, output [31:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask
    task rchk(input string n, input [9:0] a, input [31:0] e);
        rd_reg(a, v);
        chk(n, e, v);
    endtask
    task run(input [10:0] n, input [10:0] f, input [5:0] e);
        wr_reg(`BNE_OFS_CTRL, 32'h1 << `BNE_CTRL_DATA);
        feed(n, f, e);
    endtask
    task feed(input [10:0] n, input [10:0] f, input [5:0] e);
        int k;
        @(posedge clk);
        n_bytes <= n;
        flip_at <= f;
        ecc_n   <= e;
        go      <= 1'b1;
        @(posedge clk);
        go      <= 1'b0;
        repeat (2) @(posedge clk);
        for (k = 0; busy === 1'b1 && k < 3000; k++)
            @(negedge clk);
        repeat (3) @(posedge clk);
        #1;
    endtask

    initial begin
        repeat (80000) @(posedge clk);
        n_fail++;
        finish_test;
    end

    initial begin
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        rchk("isr", `BNE_OFS_ISR, 32'h0);
        rchk("cfg", `BNE_OFS_CFG, `BNE_CFG_RESET);
        rchk("ctrl", `BNE_OFS_CTRL, 32'h0);
        rchk("unmapped", 10'h3FC, 32'h0);
        wr_reg(`BNE_OFS_MASK, 32'hA5);
        rchk("mask", `BNE_OFS_MASK, 32'hA5);
        for (c = 0; c < 10; c++) begin
            nw = (nbt[c] + 3) / 4;
            wr_reg(`BNE_OFS_CFG, (c % 5) | (c / 5) << 4 | 32'h1000);
            run(c < 5 ? 11'h200 : 11'h400, 11'h7FF, 6'h00);
            for (w = 0; w < nw; w++)
                rd_reg(10'(`BNE_OFS_RES_BASE + 4 * w), red[w]);
            rchk("red_tail", 10'(`BNE_OFS_RES_BASE + 4 * nw), 32'h0);
            chk("red_top", 32'h0, red[nw - 1] >> (8 * (nbt[c] - 4 * nw + 4)));
            for (w = 0; w < nbt[c]; w++)
                u_bne_nand_src.ecc_mem[w] = 8'(red[w / 4] >> (8 * (w % 4)));
            if (c == 0)
                base = red[0];
            wr_reg(`BNE_OFS_MASK, c % 2);
            wr_reg(`BNE_OFS_CFG, (c % 5) | (c / 5) << 4 | 32'h100000);
            run(c < 5 ? 11'h200 : 11'h400, 11'h7FF, 6'(nbt[c]));
            rchk("isr_clean", `BNE_OFS_ISR, 32'h0);
            for (w = 0; w <= rwt[c % 5]; w++)
                rchk("rem", 10'(`BNE_OFS_RES_BASE + 4 * w), 32'h0);
            run(c < 5 ? 11'h200 : 11'h400, 11'h007, 6'(nbt[c]));
            chk("irq_mask", c % 2, irq);
            rchk("isr_err", `BNE_OFS_ISR, 32'h1);
            @(posedge clk);
            #1 chk("irq_clear", 32'h0, irq);
            rchk("rem_tail", 10'(`BNE_OFS_RES_BASE + 4 * rwt[c % 5]), 32'h0);
        end
        for (c = 0; c < 4; c++) begin
            wr_reg(`BNE_OFS_CFG, c == 0 ? 32'h1000 : 32'h11000);
            wr_reg(`BNE_OFS_SAREA, 32'h8);
            wr_reg(`BNE_OFS_SADDR, 32'h2);
            wr_reg(`BNE_OFS_EADDR, 32'h5);
            run(11'h208, c == 1 ? 11'h7FF : (c == 2 ? 11'h203 : 11'h206), 6'h00);
            rd_reg(`BNE_OFS_RES_BASE, v);
            if (c == 1)
                p = v;
            if (c == 0)
                chk("spare_off", base, v);
            if (c == 2)
                chk("spare_skip", p, v);
            if (c == 3)
                chk("spare_used", 32'h1, {31'h0, v !== p});
        end
        wr_reg(`BNE_OFS_CFG, 32'h10000);
        run(11'h208, 11'h204, 6'h00);
        rchk("user_pre", `BNE_OFS_RES_BASE, p);
        for (w = 0; w < 4; w++)
            u_bne_nand_src.ecc_mem[w] = 8'(p >> (8 * w));
        wr_reg(`BNE_OFS_CTRL, 32'h1 << `BNE_CTRL_USER);
        feed(11'h000, 11'h7FF, 6'h04);
        rchk("user_rem", `BNE_OFS_RES_BASE, 32'h0);
        rchk("user_isr", `BNE_OFS_ISR, 32'h0);
        wr_reg(`BNE_OFS_CFG, 32'h5);
        wr_reg(`BNE_OFS_CTRL, 32'h2);
        rchk("reserved", `BNE_OFS_SR, 32'h0);
        finish_test;
    end
endmodule // testbench
